// [src/icd_decoder.sv]
// Purpose: discrete and magnitude command decoder for a three-system instrument
// Assumes: AHB-Lite single word transfers, hclk 10 MHz
// Notes: every top output is registered
//
// The AHB-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ns
// Overview of operation
// - command 1 selects converter A, command 2 selects converter B
// - exactly one converter active, the other in standby
// - vertical off drops only vertical-unique buses
// - slant A off drops slant A and shared slant buses
// - slant B off drops slant B buses like vertical off
// - vertical on powers all vertical buses and its pulse-rejection supply
// - slant A on powers slant A, its pulse rejection and shared buses
// - slant B on powers slant B and shared buses likewise
// - vertical pulse-rejection off drops its 5 V only; vertical on restores
// - slant A and B pulse-rejection off act independently
// - all high-voltage off disables all three converters
// - three high-voltage on commands enable one converter each
// - first calibration off drives all motors to shielded position one
// - second calibration off drives all motors to shielded position two
// - calibration on exposes only the addressed motor
// - fine-mode enable hands fine mode to the magnitude pattern
// - day-night mode follows spacecraft day/night level
// - day-only and night-only freeze operation mode
// - frozen modes are reached only from day-night mode
// - vertical configure lets the 16-bit magnitude load vertical sensitivity
// - each system accepts the shared magnitude only when enabled
// - override off removes all overrides from all systems
module icd_decoder
  import icd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic orbit_day,
  input wire logic [2:0] override_in,
  output logic conv_a_on,
  output logic conv_b_on,
  output logic [2:0] bus_unique_on,
  output logic bus_slant_common_on,
  output logic [2:0] prc_on,
  output logic [2:0] hvc_on,
  output logic [5:0] cal_pos,
  output logic [2:0] cfg_en,
  output logic fine_ctrl,
  output logic day_mode,
  output logic [1:0] dn_mode,
  output logic overrides_clear
);
  logic wr_pend_reg;
  logic [7:0] addr_reg;
  logic cmd_pulse;
  logic [5:0] cmd;
  logic mag_pulse;
  logic [17:0] mag_word;
  logic [15:0] sens_v_reg;
  logic [15:0] sens_a_reg;
  logic [15:0] sens_b_reg;
  logic [15:0] fine_reg;
  icd_dn_t dn_reg;

  function automatic logic is_cmd(input logic [5:0] c, input logic [5:0] code);
    is_cmd = cmd_pulse && (c == code);
  endfunction : is_cmd

  // bus: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else if (clk_en)
    begin
      wr_pend_reg <= hsel && hready && htrans[1] && hwrite;
      if (hsel && hready && htrans[1])
        addr_reg <= haddr;
    end

  assign cmd_pulse = wr_pend_reg && clk_en && (addr_reg == ICD_OFF_CMD);
  assign cmd = hwdata[5:0];
  assign mag_pulse = wr_pend_reg && clk_en && (addr_reg == ICD_OFF_MAGCMD);
  assign mag_word = hwdata[17:0];

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (clk_en && hsel && hready && htrans[1] && !hwrite)
    begin
      case (haddr)
        ICD_OFF_STATUS: hrdata <= {7'h00, dn_mode, day_mode, fine_ctrl, cfg_en, cal_pos,
          hvc_on, prc_on, bus_slant_common_on, bus_unique_on, conv_b_on, conv_a_on};
        ICD_OFF_SENS_V: hrdata <= {16'h0000, sens_v_reg};
        ICD_OFF_SENS_A: hrdata <= {16'h0000, sens_a_reg};
        ICD_OFF_SENS_B: hrdata <= {16'h0000, sens_b_reg};
        ICD_OFF_FINE: hrdata <= {16'h0000, fine_reg};
        default: hrdata <= 32'h0000_0000;
      endcase
    end

  // converter select; selection relays keep exactly one active
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      conv_a_on <= 1'b1;
      conv_b_on <= 1'b0;
    end
    else if (clk_en)
    begin
      if (is_cmd(cmd, ICD_DC_SEL_A))
      begin
        conv_a_on <= 1'b1;
        conv_b_on <= 1'b0;
      end
      else if (is_cmd(cmd, ICD_DC_SEL_B))
      begin
        conv_a_on <= 1'b0;
        conv_b_on <= 1'b1;
      end
    end

  // supply buses: index 0 vertical, 1 slant A, 2 slant B
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      bus_unique_on <= 3'h0;
      bus_slant_common_on <= 1'b0;
      prc_on <= 3'h0;
    end
    else if (clk_en && cmd_pulse)
    begin
      case (cmd)
        ICD_DC_V_OFF: bus_unique_on[0] <= 1'b0;
        ICD_DC_A_OFF:
        begin
          bus_unique_on[1] <= 1'b0;
          bus_slant_common_on <= 1'b0;
        end
        ICD_DC_B_OFF: bus_unique_on[2] <= 1'b0;
        ICD_DC_V_ON:
        begin
          bus_unique_on[0] <= 1'b1;
          prc_on[0] <= 1'b1;
        end
        ICD_DC_A_ON:
        begin
          bus_unique_on[1] <= 1'b1;
          bus_slant_common_on <= 1'b1;
          prc_on[1] <= 1'b1;
        end
        ICD_DC_B_ON:
        begin
          bus_unique_on[2] <= 1'b1;
          bus_slant_common_on <= 1'b1;
          prc_on[2] <= 1'b1;
        end
        ICD_DC_V_PRC_OFF: prc_on[0] <= 1'b0;
        ICD_DC_A_PRC_OFF: prc_on[1] <= 1'b0;
        ICD_DC_B_PRC_OFF: prc_on[2] <= 1'b0;
        default: ;
      endcase
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      hvc_on <= 3'h0;
    else if (clk_en && cmd_pulse)
    begin
      case (cmd)
        ICD_DC_HV_OFF: hvc_on <= 3'h0;
        ICD_DC_HV_V_ON: hvc_on[0] <= 1'b1;
        ICD_DC_HV_A_ON: hvc_on[1] <= 1'b1;
        ICD_DC_HV_B_ON: hvc_on[2] <= 1'b1;
        default: ;
      endcase
    end

  // calibration motors, two bits each
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      cal_pos <= {ICD_CAL_SHIELD1, ICD_CAL_SHIELD1, ICD_CAL_SHIELD1};
    else if (clk_en && cmd_pulse)
    begin
      case (cmd)
        ICD_DC_CAL_OFF1: cal_pos <= {3{ICD_CAL_SHIELD1}};
        ICD_DC_CAL_OFF2: cal_pos <= {3{ICD_CAL_SHIELD2}};
        ICD_DC_CAL_V_ON: cal_pos[1:0] <= ICD_CAL_EXPOSED;
        ICD_DC_CAL_A_ON: cal_pos[3:2] <= ICD_CAL_EXPOSED;
        ICD_DC_CAL_B_ON: cal_pos[5:4] <= ICD_CAL_EXPOSED;
        default: ;
      endcase
    end

  // fine mode control passes to the magnitude pattern once enabled
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      fine_ctrl <= 1'b0;
      fine_reg <= 16'h0000;
    end
    else if (clk_en)
    begin
      if (is_cmd(cmd, ICD_DC_FINE_EN))
        fine_ctrl <= 1'b1;
      if (mag_pulse && mag_word[17:16] == ICD_SM_FINE && fine_ctrl)
        fine_reg <= mag_word[15:0];
    end

  // day/night: frozen modes only from following mode
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      dn_reg <= ICD_DN_FOLLOW;
    else if (clk_en && cmd_pulse)
    begin
      case (cmd)
        ICD_DC_DAY_NIGHT: dn_reg <= ICD_DN_FOLLOW;
        ICD_DC_DAY_ONLY:
          if (dn_reg == ICD_DN_FOLLOW)
            dn_reg <= ICD_DN_DAY;
        ICD_DC_NIGHT_ONLY:
          if (dn_reg == ICD_DN_FOLLOW)
            dn_reg <= ICD_DN_NIGHT;
        default: ;
      endcase
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      day_mode <= 1'b1;
      dn_mode <= 2'h0;
    end
    else if (clk_en)
    begin
      dn_mode <= dn_reg;
      case (dn_reg)
        ICD_DN_FOLLOW: day_mode <= orbit_day;
        ICD_DN_DAY: day_mode <= 1'b1;
        ICD_DN_NIGHT: day_mode <= 1'b0;
        default: day_mode <= orbit_day;
      endcase
    end

  // sensitivity: configure enables gate the shared magnitude word
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      cfg_en <= 3'h0;
      overrides_clear <= 1'b0;
    end
    else if (clk_en)
    begin
      overrides_clear <= is_cmd(cmd, ICD_DC_OVR_OFF) || (overrides_clear && override_in == 3'h0);
      if (is_cmd(cmd, ICD_DC_OVR_OFF))
        overrides_clear <= 1'b1;
      if (is_cmd(cmd, ICD_DC_CFG_V))
        cfg_en[0] <= 1'b1;
      if (is_cmd(cmd, ICD_DC_CFG_A))
        cfg_en[1] <= 1'b1;
      if (is_cmd(cmd, ICD_DC_CFG_B))
        cfg_en[2] <= 1'b1;
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      sens_v_reg <= 16'h0000;
      sens_a_reg <= 16'h0000;
      sens_b_reg <= 16'h0000;
    end
    else if (clk_en && mag_pulse && mag_word[17:16] == ICD_SM_SENS)
    begin
      if (cfg_en[0])
        sens_v_reg <= mag_word[15:0];
      if (cfg_en[1])
        sens_a_reg <= mag_word[15:0];
      if (cfg_en[2])
        sens_b_reg <= mag_word[15:0];
    end
endmodule : icd_decoder

// [src/icd_pkg.sv]
// Purpose: shared constants for the instrument command decoder
// Assumes: one AHB-Lite slave, 32-bit words
// Notes: command codes are written to the command register
package icd_pkg;
  localparam logic [7:0] ICD_OFF_CMD = 8'h00;
  localparam logic [7:0] ICD_OFF_STATUS = 8'h04;
  localparam logic [7:0] ICD_OFF_MAGCMD = 8'h08;
  localparam logic [7:0] ICD_OFF_SENS_V = 8'h0C;
  localparam logic [7:0] ICD_OFF_SENS_A = 8'h10;
  localparam logic [7:0] ICD_OFF_SENS_B = 8'h14;
  localparam logic [7:0] ICD_OFF_FINE = 8'h18;
  localparam int ICD_CMD_W = 6;
  localparam int ICD_MAG_W = 16;
  // discrete command numbers
  localparam logic [5:0] ICD_DC_SEL_A = 6'h01;
  localparam logic [5:0] ICD_DC_SEL_B = 6'h02;
  localparam logic [5:0] ICD_DC_V_OFF = 6'h03;
  localparam logic [5:0] ICD_DC_A_OFF = 6'h04;
  localparam logic [5:0] ICD_DC_B_OFF = 6'h05;
  localparam logic [5:0] ICD_DC_V_ON = 6'h06;
  localparam logic [5:0] ICD_DC_A_ON = 6'h07;
  localparam logic [5:0] ICD_DC_B_ON = 6'h08;
  localparam logic [5:0] ICD_DC_V_PRC_OFF = 6'h09;
  localparam logic [5:0] ICD_DC_A_PRC_OFF = 6'h0A;
  localparam logic [5:0] ICD_DC_B_PRC_OFF = 6'h0B;
  localparam logic [5:0] ICD_DC_HV_OFF = 6'h0C;
  localparam logic [5:0] ICD_DC_HV_V_ON = 6'h0D;
  localparam logic [5:0] ICD_DC_HV_A_ON = 6'h0E;
  localparam logic [5:0] ICD_DC_HV_B_ON = 6'h0F;
  localparam logic [5:0] ICD_DC_CAL_OFF1 = 6'h10;
  localparam logic [5:0] ICD_DC_CAL_OFF2 = 6'h11;
  localparam logic [5:0] ICD_DC_CAL_V_ON = 6'h12;
  localparam logic [5:0] ICD_DC_CAL_A_ON = 6'h13;
  localparam logic [5:0] ICD_DC_CAL_B_ON = 6'h14;
  localparam logic [5:0] ICD_DC_FINE_EN = 6'h15;
  localparam logic [5:0] ICD_DC_DAY_NIGHT = 6'h16;
  localparam logic [5:0] ICD_DC_DAY_ONLY = 6'h17;
  localparam logic [5:0] ICD_DC_NIGHT_ONLY = 6'h18;
  localparam logic [5:0] ICD_DC_CFG_V = 6'h19;
  localparam logic [5:0] ICD_DC_CFG_A = 6'h1A;
  localparam logic [5:0] ICD_DC_CFG_B = 6'h1B;
  localparam logic [5:0] ICD_DC_OVR_OFF = 6'h25;
  // magnitude command selectors (bits 17:16 of the magnitude write)
  localparam logic [1:0] ICD_SM_SENS = 2'h2;
  localparam logic [1:0] ICD_SM_FINE = 2'h3;
  // calibration motor positions
  localparam logic [1:0] ICD_CAL_SHIELD1 = 2'h0;
  localparam logic [1:0] ICD_CAL_SHIELD2 = 2'h1;
  localparam logic [1:0] ICD_CAL_EXPOSED = 2'h2;
  typedef enum logic [1:0] {ICD_DN_FOLLOW, ICD_DN_DAY, ICD_DN_NIGHT} icd_dn_t;
endpackage : icd_pkg

// [verif/icd_decoder_asserts.sv]
// Purpose: concurrent checks on the command decoder outputs
// Assumes: a command acts one cycle after its data phase
// Notes: bound into every icd_decoder
`timescale 1ns/1ns
module icd_decoder_asserts
  import icd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic orbit_day,
  input wire logic conv_a_on,
  input wire logic conv_b_on,
  input wire logic [2:0] bus_unique_on,
  input wire logic bus_slant_common_on,
  input wire logic [2:0] prc_on,
  input wire logic [2:0] hvc_on,
  input wire logic [5:0] cal_pos,
  input wire logic day_mode,
  input wire logic [1:0] dn_mode
);
  logic ph_cmd;
  logic [5:0] cmd;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      ph_cmd <= 1'b0;
    else if (clk_en)
      ph_cmd <= hsel && hready && htrans[1] && hwrite && haddr == ICD_OFF_CMD;
  // frozen clock enable swallows the command, so mask it
  assign cmd = (ph_cmd && hready && clk_en) ? hwdata[5:0] : 6'h00;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_conv_pick: assert property (cmd == ICD_DC_SEL_B |=> conv_b_on && !conv_a_on)
    else $error("converter B not picked");
  chk_conv_one: assert property (conv_a_on != conv_b_on)
    else $error("converter pair not exclusive");
  chk_vert_off: assert property (cmd == ICD_DC_V_OFF |=>
    !bus_unique_on[0] && $stable(bus_slant_common_on)) else $error("vertical off wrong");
  chk_slant_a_off: assert property (cmd == ICD_DC_A_OFF |=>
    !bus_unique_on[1] && !bus_slant_common_on && $stable(bus_unique_on[0]))
    else $error("slant A off wrong");
  chk_vert_on: assert property (cmd == ICD_DC_V_ON |=> bus_unique_on[0] && prc_on[0])
    else $error("vertical on wrong");
  chk_hv_all_off: assert property (cmd == ICD_DC_HV_OFF |=> hvc_on == 3'h0)
    else $error("high voltage not off");
  chk_cal_shield: assert property (cmd == ICD_DC_CAL_OFF1 |=> cal_pos == 6'h00)
    else $error("motors not shielded");
  chk_cal_vert: assert property (cmd == ICD_DC_CAL_V_ON |=>
    cal_pos[1:0] == ICD_CAL_EXPOSED && $stable(cal_pos[5:2])) else $error("cal V wrong");
  chk_day_follow: assert property ((dn_mode == 2'h0)[*3] |-> day_mode == $past(orbit_day))
    else $error("day level not followed");
  chk_mode_frozen: assert property ((dn_mode != 2'h0)[*3] |-> day_mode == (dn_mode == 2'h1))
    else $error("frozen mode wrong");
endmodule : icd_decoder_asserts

bind icd_decoder icd_decoder_asserts u_chk (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .orbit_day, .conv_a_on, .conv_b_on, .bus_unique_on,
  .bus_slant_common_on, .prc_on, .hvc_on, .cal_pos, .day_mode, .dn_mode);

// [verif/icd_sc_cmd.sv]
// Purpose: spacecraft commanding side as an AHB-Lite master
// Assumes: single word transfers, hready sampled at rising edges
// Notes: released write data shows the inverse of the last value
`timescale 1ns/1ns
module icd_sc_cmd
(
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [7:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial
  begin
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
    hwdata <= ~d;
  endtask : xfer
endmodule : icd_sc_cmd

// [verif/testbench.sv]
// Purpose: directed regression of the command decoder
// Assumes: commands act one cycle after the data phase
// Notes: override inputs held fixed; clock enable dropped only for one write in the power test
`timescale 1ns/1ns
module testbench
  import icd_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, orbit_day, hreadyout, hresp, conv_a_on, conv_b_on, clk_en;
  logic bus_slant_common_on, fine_ctrl, day_mode, overrides_clear;
  logic [1:0] htrans, dn_mode;
  logic [2:0] hsize, bus_unique_on, prc_on, hvc_on, cfg_en;
  logic [5:0] cal_pos;
  logic [7:0] haddr;
  logic [31:0] hwdata, hrdata, rd;
  int errors, n_tests;
  icd_decoder u_dut (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .orbit_day, .override_in(3'h0),
    .conv_a_on, .conv_b_on, .bus_unique_on, .bus_slant_common_on, .prc_on, .hvc_on, .cal_pos,
    .cfg_en, .fine_ctrl, .day_mode, .dn_mode, .overrides_clear);
  icd_sc_cmd u_sc (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic dc(input logic [5:0] c);
    u_sc.xfer(1'b1, ICD_OFF_CMD, {26'h0, c}, rd);
    @(negedge hclk);
  endtask : dc
  task automatic mg(input logic [1:0] s, input logic [15:0] d);
    u_sc.xfer(1'b1, ICD_OFF_MAGCMD, {14'h0, s, d}, rd);
  endtask : mg
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    u_sc.xfer(1'b0, a, 32'h0, rd);
    chk(rd, exp);
  endtask : rdchk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task automatic t_power();
    chk({conv_a_on, conv_b_on, bus_unique_on, prc_on, hvc_on, cfg_en, dn_mode}, 16'h8000);
    dc(ICD_DC_SEL_B);
    chk({conv_a_on, conv_b_on}, 2'h1);
    dc(ICD_DC_SEL_A);
    chk({conv_a_on, conv_b_on}, 2'h2);
    dc(ICD_DC_V_ON);
    dc(ICD_DC_A_ON);
    dc(ICD_DC_B_ON);
    chk({bus_slant_common_on, bus_unique_on, prc_on}, 7'h7F);
    dc(ICD_DC_V_OFF);
    chk({bus_slant_common_on, bus_unique_on}, 4'hE);
    dc(ICD_DC_B_OFF);
    chk(bus_unique_on, 3'h2);
    dc(ICD_DC_A_ON);
    chk({bus_slant_common_on, bus_unique_on}, 4'hA);
    dc(ICD_DC_V_ON);
    dc(ICD_DC_A_OFF);
    chk({bus_slant_common_on, bus_unique_on}, 4'h1);
    dc(ICD_DC_A_ON);
    dc(ICD_DC_B_ON);
    dc(ICD_DC_V_PRC_OFF);
    chk({bus_unique_on, prc_on}, 6'h3E);
    dc(ICD_DC_A_PRC_OFF);
    dc(ICD_DC_B_PRC_OFF);
    chk({bus_unique_on, prc_on}, 6'h38);
    dc(ICD_DC_V_ON);
    chk(prc_on, 3'h1);
    // frozen clock enable must swallow the whole write
    clk_en <= 1'b0;
    dc(ICD_DC_SEL_B);
    clk_en <= 1'b1;
    chk({conv_a_on, conv_b_on}, 2'h2);
    $display("test power done");
  endtask : t_power
  task automatic t_hv_cal();
    logic [5:0] hv[3] = '{ICD_DC_HV_V_ON, ICD_DC_HV_A_ON, ICD_DC_HV_B_ON};
    for (int i = 0; i < 3; i++)
    begin
      dc(hv[i]);
      chk(hvc_on, (32'h2 << i) - 32'h1);
    end
    dc(ICD_DC_HV_OFF);
    chk(hvc_on, 3'h0);
    dc(ICD_DC_CAL_V_ON);
    chk(cal_pos, {ICD_CAL_SHIELD1, ICD_CAL_SHIELD1, ICD_CAL_EXPOSED});
    dc(ICD_DC_CAL_OFF2);
    chk(cal_pos, {3{ICD_CAL_SHIELD2}});
    dc(ICD_DC_CAL_A_ON);
    dc(ICD_DC_CAL_B_ON);
    chk(cal_pos, {ICD_CAL_EXPOSED, ICD_CAL_EXPOSED, ICD_CAL_SHIELD2});
    dc(ICD_DC_CAL_OFF1);
    chk(cal_pos, {3{ICD_CAL_SHIELD1}});
    $display("test hv_cal done");
  endtask : t_hv_cal
  task automatic t_day();
    for (int i = 0; i < 2; i++)
    begin
      @(posedge hclk);
      orbit_day <= i[0];
      repeat (2) @(posedge hclk);
      @(negedge hclk);
      chk(day_mode, i[0]);
    end
    dc(ICD_DC_NIGHT_ONLY);
    @(negedge hclk);
    chk({dn_mode, day_mode}, 3'h4);
    dc(ICD_DC_DAY_ONLY);
    chk(dn_mode, 2'h2);
    dc(ICD_DC_DAY_NIGHT);
    orbit_day <= 1'b0;
    dc(ICD_DC_DAY_ONLY);
    @(negedge hclk);
    chk({dn_mode, day_mode}, 3'h3);
    $display("test day done");
  endtask : t_day
  task automatic t_mag();
    dc(ICD_DC_OVR_OFF);
    chk(overrides_clear, 1'b1);
    dc(ICD_DC_CFG_V);
    chk(cfg_en, 3'h1);
    mg(ICD_SM_SENS, 16'hA5C3);
    rdchk(ICD_OFF_SENS_V, 32'h0000A5C3);
    dc(ICD_DC_CFG_B);
    mg(ICD_SM_SENS, 16'h3C5A);
    rdchk(ICD_OFF_SENS_B, 32'h00003C5A);
    rdchk(ICD_OFF_SENS_A, 32'h0);
    rdchk(8'hFC, 32'h0);
    mg(ICD_SM_FINE, 16'h0C0F);
    rdchk(ICD_OFF_FINE, 32'h0);
    dc(ICD_DC_FINE_EN);
    mg(ICD_SM_FINE, 16'h0C0F);
    rdchk(ICD_OFF_FINE, 32'h00000C0F);
    chk(fine_ctrl, 1'b1);
    rdchk(ICD_OFF_STATUS, 32'h00F4007D);
    chk({hreadyout, hresp}, 2'h2);
    $display("test mag done");
  endtask : t_mag
  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  initial
  begin
    #2000000;
    errors++;
    tally_and_finish();
  end
  initial
  begin
    hresetn = 1'b0;
    orbit_day = 1'b1;
    clk_en = 1'b1;
    errors = 0;
    n_tests = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    t_power();
    t_hv_cal();
    t_day();
    t_mag();
    tally_and_finish();
  end
endmodule : testbench
